// ===== rtl/ovl_recovery_pkg.sv
// constants and carrier types for the overload recovery supervisor
package ovl_recovery_pkg;
    localparam int CODE_W = 5;
    localparam logic signed [4:0] CODE_POS_FS = 5'sh08;
    localparam logic signed [4:0] CODE_NEG_FS = -5'sh08;
    localparam int WIN_LEN = 8;
    localparam logic [3:0] OVL_THRESHOLD = 4'h5;
    localparam int RST_HOLD_CYC = 16;
    localparam int ATT_RAMP_CYC = 48;
    localparam int VALID_RESUME_CYC = 64;
    localparam logic [4:0] ATT_BOOST_DB = 5'h06;
    localparam int ATT_W = 5;
    localparam int ATT_STEP_CYC = ATT_RAMP_CYC / 6;
    // flush lengths in sample clocks per decimation setting
    localparam logic [7:0] FLUSH_DEC12 = 8'h60;
    localparam logic [7:0] FLUSH_DEC16 = 8'h80;
    localparam logic [7:0] FLUSH_DEC24 = 8'hf0;
    localparam logic [7:0] FLUSH_DEC32 = 8'hff;

    typedef enum logic [1:0] {
        DEC12,
        DEC16,
        DEC24,
        DEC32
    } decimation_select_t;

    typedef struct packed {
        logic mod_reset;
        logic [4:0] atten;
        logic data_valid;
        logic output_clean;
        logic overload;
    } ovl_status_t;
endpackage

// ===== rtl/ovl_recovery.sv
// overload supervisor for the band-pass modulator quantizer stream
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - quantizer code into the digital path is five bits wide.
// - codes span -8..+8; the extremes are negative and positive full scale.
// - overload when more than five of eight samples sit at full scale.
// - on overload, modulator state nodes are reset to zero.
// - on overload, attenuation rises six dB above programmed setting; the code saturates at code 31 when the setting exceeds 25.
// - modulator reset held sixteen sample clocks, then released.
// - attenuation steps back to programmed value over next 48 cycles.
// - further overload restarts the sequence; repeats while overload lasts.
// - valid output resumes within 64 cycles after input is in range; the code counts the 64 cycles from the end of the attenuation ramp.
// - output counted clean only after corrupted samples flush filters.
// - settling shorter with decimation twelve or sixteen than larger.
module ovl_recovery
    import ovl_recovery_pkg::*;
#(
    parameter int HOLD_CYC = RST_HOLD_CYC,
    parameter int RAMP_CYC = ATT_RAMP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic signed [ovl_recovery_pkg::CODE_W-1:0] quant_code,
    input wire logic [ovl_recovery_pkg::ATT_W-1:0] atten_prog,
    input wire ovl_recovery_pkg::decimation_select_t decimation_select,
    output var ovl_recovery_pkg::ovl_status_t status
);
    import ovl_recovery_pkg::*;

    // --------------------------------------------------------------
    // derived timing
    // --------------------------------------------------------------
    // one attenuation step per boost dB, spread over the whole ramp;
    // a ramp that is not a multiple of the boost truncates each step
    localparam int STEP_CYC = RAMP_CYC / int'(ATT_BOOST_DB);
    localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);
    localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);
    localparam logic [2:0] BOOST_INIT = 3'(ATT_BOOST_DB);
    localparam logic [2:0] BOOST_LAST = 3'h1;
    localparam logic [2:0] BOOST_STEP = 3'h1;
    localparam logic [7:0] CNT_STEP = 8'h01;
    localparam logic [6:0] RESUME_INIT = 7'(VALID_RESUME_CYC);
    localparam logic [6:0] RESUME_LAST = 7'h01;
    localparam logic [7:0] FLUSH_LAST = 8'h01;
    localparam logic [4:0] ATT_MAX = 5'h1f;

    // idle, modulator held at zero, attenuation ramping back
    typedef enum logic [1:0] {
        IDLE,
        HOLD,
        RAMP
    } state_t;

    // --------------------------------------------------------------
    // full-scale decode
    // --------------------------------------------------------------
    // code is on-chip logic on the same clock, so no synchroniser
    wire logic is_fs;
    wire logic is_fs_pos;
    wire logic is_fs_neg;

    assign is_fs_pos = (quant_code == CODE_POS_FS);
    assign is_fs_neg = (quant_code == CODE_NEG_FS);
    assign is_fs = is_fs_pos | is_fs_neg;

    // --------------------------------------------------------------
    // eight-sample window
    // --------------------------------------------------------------
    logic [WIN_LEN-1:0] win_r;
    logic [WIN_LEN-1:0] win_nxt;
    logic [3:0] fs_cnt_r;
    logic [3:0] fs_cnt_nxt;
    wire logic fs_in;
    wire logic fs_out;
    wire logic ovl_det;

    assign fs_in = is_fs;
    assign fs_out = win_r[WIN_LEN-1];
    assign win_nxt = {win_r[WIN_LEN-2:0], fs_in};
    // running count: add newest, drop the sample leaving the window,
    // so no adder tree over the whole window is needed
    assign fs_cnt_nxt = fs_cnt_r + {3'h0, fs_in}
                        - {3'h0, fs_out};
    assign ovl_det = fs_cnt_r > OVL_THRESHOLD;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            win_r <= '0;
        end else begin
            win_r <= win_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_cnt_r <= 4'h0;
        end else begin
            fs_cnt_r <= fs_cnt_nxt;
        end
    end

    // --------------------------------------------------------------
    // recovery sequence
    // --------------------------------------------------------------
    state_t state_r;
    state_t state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [2:0] boost_r;
    logic [2:0] boost_nxt;
    wire logic in_hold;
    wire logic start;
    wire logic hold_done;
    wire logic step_due;
    wire logic boost_last;
    wire logic ramp_done;

    assign in_hold = state_r == HOLD;
    // new detections ignored while the modulator is held in reset,
    // since the window still holds pre-reset codes
    assign start = ovl_det && !in_hold;
    assign hold_done = cnt_r == HOLD_LAST;
    assign step_due = cnt_r == STEP_LAST;
    assign boost_last = boost_r == BOOST_LAST;
    assign ramp_done = step_due && boost_last;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + CNT_STEP;
        boost_nxt = boost_r;
        case (state_r)
            IDLE: begin
                cnt_nxt = '0;
            end
            HOLD: begin
                if (hold_done) begin
                    state_nxt = RAMP;
                    cnt_nxt = '0;
                end
            end
            RAMP: begin
                // one dB per step, as many steps as the boost
                if (step_due) begin
                    cnt_nxt = '0;
                    boost_nxt = boost_r - BOOST_STEP;
                end
                if (ramp_done) begin
                    state_nxt = IDLE;
                end
            end
            default: begin
                state_nxt = IDLE;
                cnt_nxt = '0;
            end
        endcase
        // a detection outside the hold restarts from full boost
        if (start) begin
            state_nxt = HOLD;
            cnt_nxt = '0;
            boost_nxt = BOOST_INIT;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            boost_r <= '0;
        end else begin
            boost_r <= boost_nxt;
        end
    end

    // --------------------------------------------------------------
    // attenuation
    // --------------------------------------------------------------
    wire logic [5:0] att_base;
    wire logic [5:0] boost_ext;
    wire logic [5:0] att_sum;
    wire logic [4:0] att_sat;

    // boost follows the next state so it lands with the reset edge
    assign att_base = {1'b0, atten_prog};
    assign boost_ext = {3'h0, boost_nxt};
    assign att_sum = att_base + boost_ext;
    // saturate rather than wrap past the top attenuation code
    assign att_sat = att_sum[ATT_W] ? ATT_MAX : att_sum[ATT_W-1:0];

    // --------------------------------------------------------------
    // valid resume
    // --------------------------------------------------------------
    logic [6:0] resume_r;
    logic [6:0] resume_nxt;
    wire logic busy_nxt;
    wire logic resume_done;

    assign busy_nxt = state_nxt != IDLE;
    assign resume_done = resume_r == '0;

    // counts down only once the whole sequence has ended
    always_comb begin
        resume_nxt = resume_r;
        if (busy_nxt) begin
            resume_nxt = RESUME_INIT;
        end else if (!resume_done) begin
            resume_nxt = resume_r - 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resume_r <= '0;
        end else begin
            resume_r <= resume_nxt;
        end
    end

    // --------------------------------------------------------------
    // filter flush
    // --------------------------------------------------------------
    logic [7:0] flush_r;
    logic [7:0] flush_nxt;
    wire logic [7:0] flush_len;
    wire logic flush_done;

    // larger decimation keeps bad samples longer in the last stage
    assign flush_len = (decimation_select == DEC12) ? FLUSH_DEC12 :
                       (decimation_select == DEC16) ? FLUSH_DEC16 :
                       (decimation_select == DEC24) ? FLUSH_DEC24 :
                       FLUSH_DEC32;
    assign flush_done = flush_r == '0;

    // length reloads every busy cycle, so a late change of
    // decimation still applies; flushing waits for good data
    always_comb begin
        flush_nxt = flush_r;
        if (busy_nxt) begin
            flush_nxt = flush_len;
        end else if (resume_done && !flush_done) begin
            flush_nxt = flush_r - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flush_r <= '0;
        end else begin
            flush_r <= flush_nxt;
        end
    end

    // --------------------------------------------------------------
    // output decode
    // --------------------------------------------------------------
    wire logic idle_nxt;
    wire logic mod_reset_nxt;
    wire logic data_valid_nxt;
    wire logic output_clean_nxt;
    ovl_status_t status_nxt;

    assign idle_nxt = !busy_nxt;
    assign mod_reset_nxt = state_nxt == HOLD;
    // flags rise with the last count so they line up with the
    // counters reaching zero once registered
    assign data_valid_nxt = idle_nxt && resume_r <= RESUME_LAST;
    assign output_clean_nxt = idle_nxt && resume_done &&
                              flush_r <= FLUSH_LAST;

    always_comb begin
        status_nxt = '0;
        status_nxt.mod_reset = mod_reset_nxt;
        status_nxt.atten = att_sat;
        status_nxt.data_valid = data_valid_nxt;
        status_nxt.output_clean = output_clean_nxt;
        status_nxt.overload = start;
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else begin
            status <= status_nxt;
        end
    end
endmodule

`default_nettype wire

// ===== verification/ovl_recovery_chk.sv
// assertions on the overload supervisor ports
`timescale 1ns/1ns
`default_nettype none
module ovl_recovery_chk
    import ovl_recovery_pkg::*;
#(
    parameter int HOLD_CYC = 16,
    parameter int RAMP_CYC = 48
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ATT_W-1:0] atten_prog,
    input wire decimation_select_t decimation_select,
    input wire ovl_status_t status
);
    logic [9:0] low_r;
    logic [4:0] hold_r;
    wire [4:0] boost = (atten_prog > 5'h19) ? 5'h1f : atten_prog + 5'h06;
    // cycles since release saturate, so late checks stay reachable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_r <= 10'h000;
            hold_r <= 5'h00;
        end else begin
            low_r <= status.mod_reset ? 10'h000 : low_r + {9'h0, ~&low_r};
            hold_r <= status.mod_reset ? hold_r + 5'h01 : 5'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_det; $rose(status.mod_reset) |-> status.overload; endproperty
    property p_boost; status.overload |-> status.atten == boost; endproperty
    property p_hold; $fell(status.mod_reset) |-> hold_r == HOLD_CYC; endproperty
    property p_ramp; low_r == RAMP_CYC |-> status.atten == atten_prog;
    endproperty
    property p_pulse; status.overload |=> !status.overload; endproperty
    property p_refuse;
        status.mod_reset && $past(status.mod_reset) |-> !status.overload;
    endproperty
    property p_resume; low_r == 10'h072 |-> status.data_valid; endproperty
    property p_fast;
        decimation_select == DEC12 && low_r == 10'h0dc |-> status.output_clean;
    endproperty
    a_det: assert property (p_det) else $error("reset w/o overload");
    a_boost: assert property (p_boost) else $error("bad boost");
    a_hold: assert property (p_hold) else $error("bad hold");
    a_ramp: assert property (p_ramp) else $error("ramp not done");
    a_pulse: assert property (p_pulse) else $error("long pulse");
    a_refuse: assert property (p_refuse) else $error("not held off");
    a_resume: assert property (p_resume) else $error("not valid");
    a_fast: assert property (p_fast) else $error("slow flush");
    c_ovl: cover property (status.overload);
    c_ramp: cover property (low_r == RAMP_CYC);
    c_clean: cover property ($rose(status.output_clean));
endmodule
`default_nettype wire

// ===== verification/filter_sink.sv
// downstream filter stand-in: counts clean output samples
`timescale 1ns/1ns
`default_nettype none
module filter_sink
    import ovl_recovery_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ovl_status_t status,
    output logic [15:0] n_clean
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            n_clean <= 16'h0000;
        end else if (status.output_clean && status.data_valid) begin
            n_clean <= n_clean + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== verification/test_ovl_recovery.sv
// random and corner stimulus for the overload supervisor
`timescale 1ns/1ns
`default_nettype none
module test_ovl_recovery;
    import ovl_recovery_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic signed [4:0] quant_code = 5'sh00;
    logic [4:0] atten_prog = 5'h00;
    decimation_select_t decimation_select = DEC12;
    ovl_status_t status;
    logic [15:0] n_clean;
    logic seen_ovl = 1'b0;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 55134;
    int cycles = 0;
    int n;
    int t_clean[4];
    ovl_recovery u_dut (.clk(clk), .rst_b(rst_b), .quant_code(quant_code),
        .atten_prog(atten_prog), .decimation_select(decimation_select),
        .status(status));
    filter_sink u_sink (.clk(clk), .rst_b(rst_b), .status(status),
        .n_clean(n_clean));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end
    function automatic logic [4:0] boosted(input logic [4:0] p);
        return (p > 5'h19) ? 5'h1f : p + 5'h06;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // in-range codes never reach full scale, so they never feed the window
    task automatic quiet(input int k);
        repeat (k) begin
            @(posedge clk);
            quant_code <= 5'($random(seed) % 8);
            if (status.overload === 1'b1) seen_ovl = 1'b1;
        end
    endtask
    task automatic burst(input int n_fs);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            quant_code <= (i >= n_fs) ? 5'sh00 : i[0] ? CODE_NEG_FS : CODE_POS_FS;
        end
        seen_ovl = 1'b0;
    endtask
    task automatic wait_release();
        repeat (40) if (status.mod_reset === 1'b1) quiet(1);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            atten_prog <= (d == 3) ? 5'h1c : 5'($unsigned($random(seed)) % 26);
            decimation_select <= decimation_select_t'(d);
            quiet(20);
            check(status.atten, atten_prog);
            burst(5);
            quiet(8);
            check(seen_ovl, 1'b0);
            burst(6);
            quiet(5);
            check(seen_ovl, 1'b1);
            check({status.mod_reset, status.data_valid}, 2'b10);
            check(status.atten, boosted(atten_prog));
            wait_release();
            quiet(10);
            burst(6);
            quiet(5);
            check(seen_ovl & status.mod_reset, 1'b1);
            wait_release();
            quiet(52);
            check(status.atten, atten_prog);
            n = 0;
            while (status.output_clean !== 1'b1 && n < 1000) begin
                quiet(1);
                n++;
            end
            t_clean[d] = n;
            check(status.data_valid, 1'b1);
        end
        check(t_clean[0] < t_clean[3] && t_clean[1] < t_clean[2], 1'b1);
        check(n_clean != 16'h0000, 1'b1);
        complete_run();
    end
endmodule
bind ovl_recovery ovl_recovery_chk #(.HOLD_CYC(HOLD_CYC), .RAMP_CYC(RAMP_CYC))
    u_chk (.clk(clk), .rst_b(rst_b), .atten_prog(atten_prog),
    .decimation_select(decimation_select), .status(status));
`default_nettype wire
